// ===== src/lpdp_host.v
/*
  Host controller that writes and reads back a latched parallel DAC.
  Assumes the data lines are resolved by the surroundings from parallel_data_lines_oe.
*/
`include "lpdp_regs.vh"

module lpdp_host #(
  parameter DATA_W   = `LPDP_DATA_W,
  parameter SEL_W    = `LPDP_SEL_W,
  parameter LINES    = `LPDP_SEL_LINES,
  parameter DAC_SEL  = 0,
  parameter WAIT_ST  = 1,
  parameter LOW_CYC  = `LPDP_CS_LOW_CYC,
  parameter HIGH_CYC = `LPDP_CS_HIGH_CYC
) (
  input  wire              clk,
  input  wire              reset,
  input  wire              req_valid,
  input  wire              req_write,
  input  wire [DATA_W-1:0] req_wdata,
  output wire              req_ready,
  output reg  [DATA_W-1:0] rsp_rdata,
  output reg               rsp_valid,
  output wire [LINES-1:0]  memory_select_lines_n,
  output wire              dac_cs_n,
  output reg               rw,
  output reg  [DATA_W-1:0] parallel_data_lines_out,
  output reg               parallel_data_lines_oe,
  input  wire [DATA_W-1:0] parallel_data_lines_in
);

  localparam ST_IDLE = 2'd0;
  localparam ST_LOW  = 2'd1;
  localparam ST_HIGH = 2'd2;
  localparam LOW_N   = LOW_CYC + WAIT_ST;
  localparam [SEL_W-1:0] DAC_IDX = DAC_SEL;

  reg [1:0]  state_q;
  reg [1:0]  state_d;
  reg [7:0]  cnt_q;
  reg [7:0]  cnt_d;
  reg        strobe_q;
  reg        strobe_d;
  reg        is_wr_q;
  reg        is_wr_d;
  wire [SEL_W-1:0] dac_index;

  assign dac_index = DAC_IDX;
  assign req_ready = (state_q == ST_IDLE);

  // ----------------------------------------------------------------
  // Chip select decode
  // ----------------------------------------------------------------
  // fixed DAC_SEL index to chip select
  lpdp_sel_decode #(
    .SEL_W (SEL_W),
    .LINES (LINES)
  ) u_dec (
    .sel         (dac_index),
    .strobe      (strobe_q),
    .sel_lines_n (memory_select_lines_n)
  );

  assign dac_cs_n = memory_select_lines_n[DAC_SEL];

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  always @* begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    strobe_d = strobe_q;
    is_wr_d  = is_wr_q;
    case (state_q)
      ST_IDLE: begin
        if (req_valid) begin
          is_wr_d  = req_write;
          strobe_d = 1'b1;
          cnt_d    = LOW_N[7:0];
          state_d  = ST_LOW;
        end
      end
      ST_LOW: begin
        if (cnt_q > 8'd1) begin
          cnt_d = cnt_q - 8'd1;
        end else begin
          strobe_d = 1'b0;
          cnt_d    = HIGH_CYC[7:0];
          state_d  = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (cnt_q > 8'd1) begin
          cnt_d = cnt_q - 8'd1;
        end else begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d  = ST_IDLE;
        strobe_d = 1'b0;
      end
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      state_q                 <= ST_IDLE;
      cnt_q                   <= 8'h00;
      strobe_q                <= 1'b0;
      is_wr_q                 <= 1'b0;
      rw                      <= 1'b1;
      parallel_data_lines_out <= {DATA_W{1'b0}};
      parallel_data_lines_oe  <= 1'b0;
      rsp_rdata               <= {DATA_W{1'b0}};
      rsp_valid               <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      strobe_q  <= strobe_d;
      is_wr_q   <= is_wr_d;
      rsp_valid <= 1'b0;
      if (state_q == ST_IDLE && req_valid) begin
        rw <= ~req_write;
        parallel_data_lines_out <= req_wdata;
        parallel_data_lines_oe  <= req_write;
      end
      if (state_q == ST_LOW && cnt_q == 8'd1 && !is_wr_q) begin
        rsp_rdata <= parallel_data_lines_in;
        rsp_valid <= 1'b1;
      end
      if (state_q == ST_HIGH && cnt_q == 8'd1) begin
        parallel_data_lines_oe <= 1'b0;
        rw                     <= 1'b1;
      end
    end
  end

endmodule

// ===== src/lpdp_regs.vh
/*
  Constants for the host-side controller of a latched parallel DAC port.
  Assumes a 40 MHz system clock and a device with no clock of its own.
*/
// What this block does
// - The data word on the parallel data lines is 8, 10 or 12 bits wide, set by the variant in use.
// - A write drives chip select low with read/write low while the new word sits on the data lines.
// - The input latch is transparent while chip select is low, so every write ends with chip select raised again.
// - A read holds read/write high and drives chip select low.
// - The host reaches the converter by decoding the fixed select index DAC_SEL into chip select; requests carry no address.
// - The host may add one wait state to each access to meet the device access time.
// - The host may use a plain asynchronous memory write cycle to drive the device inputs.
// - The host may decode address bits into several memory select lines and use one as chip select.
`ifndef LPDP_REGS_VH
`define LPDP_REGS_VH

// ----------------------------------------------------------------
// Widths and timing
// ----------------------------------------------------------------
`define LPDP_DATA_W      12
`define LPDP_CLK_MHZ     40
`define LPDP_CS_LOW_NS   17
`define LPDP_CS_HIGH_NS  17
`define LPDP_CS_LOW_CYC  ((`LPDP_CS_LOW_NS * `LPDP_CLK_MHZ + 999) / 1000)
`define LPDP_CS_HIGH_CYC ((`LPDP_CS_HIGH_NS * `LPDP_CLK_MHZ + 999) / 1000)
`define LPDP_SEL_W       2
`define LPDP_SEL_LINES   4

`endif

// ===== src/lpdp_sel_decode.v
/*
  Decodes a select index into active-low memory select lines.
  Assumes the index is held stable while the strobe is high.
*/
`include "lpdp_regs.vh"

module lpdp_sel_decode #(
  parameter SEL_W = `LPDP_SEL_W,
  parameter LINES = `LPDP_SEL_LINES
) (
  input  wire [SEL_W-1:0] sel,
  input  wire             strobe,
  output wire [LINES-1:0] sel_lines_n
);

  // ----------------------------------------------------------------
  // One line per select value
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < LINES; i = i + 1) begin : g_line
      localparam [SEL_W-1:0] LINE_IDX = i;
      assign sel_lines_n[i] = ~(strobe && (sel == LINE_IDX));
    end
  endgenerate

endmodule

// ===== testbench/lpdp_host_sva.sv
/* Checker for the DAC host port pins.
   Assumes it is bound to lpdp_host. */
module lpdp_host_sva #(parameter DATA_W = 12, LINES = 4) (input wire logic clk, reset, req_valid, req_write,
  req_ready, rsp_valid, dac_cs_n, rw, parallel_data_lines_oe, input wire logic [DATA_W-1:0] req_wdata,
  rsp_rdata, parallel_data_lines_out, parallel_data_lines_in, input wire logic [LINES-1:0] memory_select_lines_n);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  AST_START: assert property (req_valid && req_ready |=> !dac_cs_n && rw != $past(req_write))
    else $error("access start wrong");
  AST_WDATA: assert property ($fell(dac_cs_n) && !rw |-> parallel_data_lines_oe &&
    parallel_data_lines_out == $past(req_wdata)) else $error("write word wrong");
  AST_HOLD: assert property (!dac_cs_n && $past(!dac_cs_n) |-> $stable(rw) &&
    $stable(parallel_data_lines_out)) else $error("access changed while selected");
  AST_LOW2: assert property ($fell(dac_cs_n) |=> !dac_cs_n ##1 dac_cs_n) else $error("select width wrong");
  AST_RELEASE: assert property (rw |-> !parallel_data_lines_oe) else $error("host drives during read");
  AST_MAP: assert property (dac_cs_n == memory_select_lines_n[0] &&
    &memory_select_lines_n[LINES-1:1]) else $error("select decode wrong");
  AST_RSP: assert property (rsp_valid |-> $rose(dac_cs_n) && rw &&
    rsp_rdata == $past(parallel_data_lines_in)) else $error("readback wrong");
  AST_READY: assert property ($rose(dac_cs_n) |=> req_ready) else $error("ready late");
  C_WR: cover property ($rose(dac_cs_n) && !rw);
  C_RD: cover property (rsp_valid);
  C_WAIT: cover property (req_valid && !req_ready);
endmodule
bind lpdp_host lpdp_host_sva #(.DATA_W(DATA_W), .LINES(LINES)) u_sva (.*);

// ===== testbench/lpdp_dac_model.sv
/* Behavioural model of the latched parallel DAC.
   Assumes the host drives cs_n, rw and its data drivers. */
module lpdp_dac_model (input wire logic clk, cs_n, rw, host_oe, input wire logic [11:0] host_out,
  output logic [11:0] lines, output logic [11:0] dac_q);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] in_q = 12'h000;
  logic [11:0] last_q = 12'h000;
  initial dac_q = 12'h000;
  always @* if (!cs_n) in_q = rw ? dac_q : lines;
  always @(posedge cs_n) if (!rw) dac_q = in_q;
  // host word while host_oe, else drive reads, else inverse of last level
  always @* lines = host_oe ? host_out : (!cs_n && rw) ? in_q : ~last_q;
  always @(posedge clk) last_q <= lines;
endmodule

// ===== testbench/lpdp_host_tb.sv
/* Self-checking bench for the DAC host controller.
   Assumes the DAC model resolves the data lines. */
module lpdp_host_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, reset = 1, req_valid = 0, req_write = 0, ready, rsp_valid, cs_n, rw, oe;
  logic [11:0] req_wdata = 12'h000, lines, dac_q, out, rdata, rsp_rdata;
  logic [3:0] sel_n;
  int errors = 0, checked = 0, cyc = 0;
  logic [24:0] rows [8] = '{25'h0000000, 25'h1abcabc, 25'h0000abc, 25'h1ffffff,
                            25'h0000fff, 25'h1000000, 25'h0000000, 25'h1555555};
  lpdp_host u_dut (.clk(clk), .reset(reset), .req_valid(req_valid), .req_write(req_write), .req_wdata(req_wdata),
    .req_ready(ready), .rsp_rdata(rsp_rdata), .rsp_valid(rsp_valid), .memory_select_lines_n(sel_n), .dac_cs_n(cs_n),
    .rw(rw), .parallel_data_lines_out(out), .parallel_data_lines_oe(oe), .parallel_data_lines_in(lines));
  lpdp_dac_model u_dac (.clk(clk), .cs_n(cs_n), .rw(rw), .host_oe(oe), .host_out(out), .lines(lines), .dac_q(dac_q));
  task automatic chk(input string n, input logic [11:0] e, g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic finish_access;
    req_valid <= 0;
    rdata = 12'hxxx;
    repeat (3) @(posedge clk) if (rsp_valid) rdata = rsp_rdata;
  endtask
  always #12.5 clk = ~clk;
  always @(posedge clk) if (++cyc == 2000) begin
    errors++;
    tally_and_finish;
  end
  initial begin
    repeat (8) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    chk("idle", 12'h01a, {7'h00, cs_n, rw, oe, ready, rsp_valid});
    chk("dac", 12'h000, dac_q);
    $display("reset test done");
    foreach (rows[i]) begin
      req_valid <= 1;
      req_write <= rows[i][24];
      req_wdata <= rows[i][23:12];
      do @(posedge clk); while (!ready);
      finish_access;
      chk(rows[i][24] ? "dac" : "readback", rows[i][11:0], rows[i][24] ? dac_q : rdata);
      $display("row %0d done", i);
    end
    req_valid <= 1;
    req_write <= 1;
    req_wdata <= 12'h123;
    do @(posedge clk); while (!ready);
    req_write <= 0;
    do @(posedge clk); while (!ready);
    finish_access;
    chk("back_to_back", 12'h123, rdata);
    $display("back to back test done");
    req_valid <= 1;
    req_write <= 1;
    req_wdata <= 12'h2c4;
    @(posedge clk);
    req_valid <= 0;
    @(posedge clk);
    reset <= 1;
    repeat (2) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    chk("idle_mid", 12'h01a, {7'h00, cs_n, rw, oe, ready, rsp_valid});
    req_valid <= 1;
    req_write <= 1;
    req_wdata <= 12'h3e1;
    do @(posedge clk); while (!ready);
    finish_access;
    chk("after_reset", 12'h3e1, dac_q);
    $display("mid-run reset test done");
    tally_and_finish;
  end
endmodule
